// *** rtl/ipq_prefetch_queue.sv ***
// ipq_prefetch_queue: fetches instruction words ahead of execution into a queue.
// assumes memory answers a fetch while it stands, with mem_rdata and mem_ecc_err;
// the execute stage pulls with issue_ready and redirects with flush.
`timescale 1ns/1ps
module ipq_prefetch_queue
(
  input wire logic clock,
  input wire logic srst,
  input wire logic flush,
  input wire logic [21:0] flush_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ecc_err,
  input wire logic issue_ready,
  output ipq_pkg::ipq_fetch_t fetch,
  output logic issue_valid,
  output ipq_pkg::ipq_entry_t issue,
  output logic illegal_op_trap,
  output logic ecc_fault_trap
);
  ipq_pkg::ipq_entry_t queue [ipq_pkg::FLASH_DEPTH];
  ipq_pkg::ipq_entry_t next_slot;
  logic [3:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [4:0] count, next_count;
  logic [4:0] inflight, limit;
  logic [21:0] fetch_addr, next_fetch_addr;
  ipq_pkg::ipq_fetch_t next_fetch;
  ipq_pkg::ipq_region_t fetch_region, ret_region, last_region;
  logic ret_pending, next_ret_pending;
  logic [21:0] ret_addr, next_ret_addr;
  logic pop, push, next_issue_valid, next_illegal, next_ecc;
  ipq_pkg::ipq_entry_t next_issue;

  ipq_region_decode u_fetch_dec
  (
    .addr(fetch_addr),
    .region(fetch_region)
  );

  ipq_region_decode u_ret_dec
  (
    .addr(ret_addr),
    .region(ret_region)
  );

  // depth follows the region being fetched from
  function automatic logic [4:0] depth_of(input ipq_pkg::ipq_region_t r);
    depth_of = (r == ipq_pkg::IPQ_FLASH) ? 5'(ipq_pkg::FLASH_DEPTH) : 5'(ipq_pkg::RAM_DEPTH);
  endfunction

  assign limit = depth_of(fetch_region == ipq_pkg::IPQ_UNMAPPED ? last_region : fetch_region);
  assign inflight = count + 5'(ret_pending);
  assign pop = issue_valid && issue_ready;

  always_comb
  begin
    next_slot.word = mem_rdata;
    next_slot.addr = ret_addr;
    next_slot.bad_opcode = 1'b0;
    next_slot.ecc_fault = 1'b0;
    unique case (ret_region)
      ipq_pkg::IPQ_RAM:
      begin
        next_slot.ecc_fault = 1'b0;
      end
      ipq_pkg::IPQ_FLASH:
      begin
        next_slot.ecc_fault = mem_ecc_err;
      end
      ipq_pkg::IPQ_UNMAPPED:
      begin
        // past the last valid word: flash overrun reports ecc, ram overrun an invalid opcode
        if (last_region == ipq_pkg::IPQ_FLASH)
        begin
          next_slot.ecc_fault = 1'b1;
        end
        else
        begin
          next_slot.word = ipq_pkg::INVALID_OPCODE;
          next_slot.bad_opcode = 1'b1;
        end
      end
      default:
      begin
        next_slot.bad_opcode = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    push = ret_pending && !flush;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count = count;
    next_fetch_addr = fetch_addr;
    next_fetch.valid = 1'b0;
    next_fetch.addr = fetch_addr;
    next_ret_pending = 1'b0;
    next_ret_addr = ret_addr;
    next_issue_valid = issue_valid && !pop;
    next_issue = issue;
    next_illegal = 1'b0;
    next_ecc = 1'b0;
    if (flush)
    begin
      // discarded words never reach execution, so their faults vanish
      next_rd_ptr = 4'h0;
      next_wr_ptr = 4'h0;
      next_count = 5'h00;
      next_fetch_addr = flush_addr;
      next_issue_valid = 1'b0;
    end
    else
    begin
      if (push)
      begin
        next_wr_ptr = wr_ptr + 4'h1;
      end
      if ((!issue_valid || pop) && count != 5'h00)
      begin
        next_issue = queue[rd_ptr];
        next_issue_valid = 1'b1;
        next_rd_ptr = rd_ptr + 4'h1;
      end
      next_count = count + 5'(push) - 5'(next_rd_ptr != rd_ptr);
      // lookahead keeps fetching until the region depth is reached
      if (inflight < limit)
      begin
        next_fetch.valid = 1'b1;
        next_fetch.addr = fetch_addr;
        next_ret_pending = 1'b1;
        next_ret_addr = fetch_addr;
        next_fetch_addr = fetch_addr + 22'h00_0001;
      end
    end
    if (pop)
    begin
      next_illegal = issue.bad_opcode;
      next_ecc = issue.ecc_fault;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      count <= 5'h00;
      fetch_addr <= ipq_pkg::FIRST_LOCAL_RAM_BLOCK_BASE;
      fetch <= '0;
      ret_pending <= 1'b0;
      ret_addr <= 22'h00_0000;
      last_region <= ipq_pkg::IPQ_RAM;
      issue_valid <= 1'b0;
      issue <= '0;
      illegal_op_trap <= 1'b0;
      ecc_fault_trap <= 1'b0;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
      fetch_addr <= next_fetch_addr;
      fetch <= next_fetch;
      ret_pending <= next_ret_pending;
      ret_addr <= next_ret_addr;
      if (fetch_region != ipq_pkg::IPQ_UNMAPPED)
      begin
        last_region <= fetch_region;
      end
      issue_valid <= next_issue_valid;
      issue <= next_issue;
      illegal_op_trap <= next_illegal;
      ecc_fault_trap <= next_ecc;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      queue[wr_ptr] <= next_slot;
    end
  end

  a_ram_depth_cap: assert property (@(posedge clock) disable iff (srst)
    (last_region == ipq_pkg::IPQ_RAM && fetch_region != ipq_pkg::IPQ_FLASH) |-> count <= 5'(ipq_pkg::RAM_DEPTH))
    else $error("ram queue exceeded eight words");
  a_flash_depth_cap: assert property (@(posedge clock) disable iff (srst)
    count <= 5'(ipq_pkg::FLASH_DEPTH))
    else $error("queue exceeded sixteen words");
  a_trap_on_issue: assert property (@(posedge clock) disable iff (srst)
    illegal_op_trap |-> $past(issue_valid && issue_ready && issue.bad_opcode))
    else $error("invalid opcode trap without an issued bad word");
  a_ecc_on_issue: assert property (@(posedge clock) disable iff (srst)
    ecc_fault_trap |-> $past(issue_valid && issue_ready && issue.ecc_fault))
    else $error("ecc trap without an issued faulty word");
  a_flush_quiet: assert property (@(posedge clock) disable iff (srst)
    flush |=> !issue_valid ##1 !illegal_op_trap && !ecc_fault_trap)
    else $error("flushed word reached execution");
  a_seam_clean: assert property (@(posedge clock) disable iff (srst)
    (push && ret_addr <= ipq_pkg::SECOND_LOCAL_RAM_BLOCK_END) |-> !next_slot.bad_opcode && !next_slot.ecc_fault)
    else $error("fault on valid local ram word");
  a_overrun_marked: assert property (@(posedge clock) disable iff (srst)
    (push && ret_region == ipq_pkg::IPQ_UNMAPPED) |-> (next_slot.bad_opcode ^ next_slot.ecc_fault))
    else $error("out of range word not marked");
  a_fetch_return: assert property (@(posedge clock) disable iff (srst)
    fetch.valid |-> ret_pending && ret_addr == fetch.addr)
    else $error("fetch not tracked for return");
endmodule

// *** rtl/ipq_pkg.sv ***
// ipq_pkg: shared constants and carrier types for the instruction prefetch queue.
// assumes a 22-bit word address space and 16-bit instruction words.
package ipq_pkg;
  localparam int ADDR_W = 22;
  localparam int WORD_W = 16;
  localparam int RAM_DEPTH = 8;
  localparam int FLASH_DEPTH = 16;
  localparam int PTR_W = 5;
  // memory map of the fetch space, word addresses
  localparam logic [21:0] FIRST_LOCAL_RAM_BLOCK_BASE = 22'h00_0000;
  localparam logic [21:0] FIRST_LOCAL_RAM_BLOCK_END = 22'h00_03FF;
  localparam logic [21:0] SECOND_LOCAL_RAM_BLOCK_END = 22'h00_07FF;
  localparam logic [21:0] SECOND_LOCAL_RAM_BLOCK_CODE_END = 22'h00_07F7;
  localparam logic [21:0] SHARED_RAM_BLOCK_ELEVEN_BASE = 22'h01_7000;
  localparam logic [21:0] SHARED_RAM_BLOCK_ELEVEN_END = 22'h01_7FFF;
  localparam logic [21:0] SHARED_RAM_BLOCK_FIFTEEN_BASE = 22'h01_B000;
  localparam logic [21:0] SHARED_RAM_BLOCK_FIFTEEN_END = 22'h01_BFFF;
  localparam logic [21:0] FLASH_BASE = 22'h08_0000;
  localparam logic [21:0] FLASH_END = 22'h0B_FFFF;
  localparam logic [15:0] INVALID_OPCODE = 16'h0000;

  typedef enum logic [1:0] {IPQ_UNMAPPED, IPQ_RAM, IPQ_FLASH} ipq_region_t;

  // one queue entry: word plus what the fetch left behind it
  typedef struct packed {
    logic [15:0] word;
    logic [21:0] addr;
    logic bad_opcode;
    logic ecc_fault;
  } ipq_entry_t;

  // fetch request towards memory
  typedef struct packed {
    logic valid;
    logic [21:0] addr;
  } ipq_fetch_t;
endpackage

// *** rtl/ipq_region_decode.sv ***
// ipq_region_decode: classifies a fetch word address by memory region.
// assumes the map in ipq_pkg; contiguous blocks decode as one valid span.
`timescale 1ns/1ps
module ipq_region_decode
(
  input wire logic [21:0] addr,
  output ipq_pkg::ipq_region_t region
);
  always_comb
  begin
    // first and second local ram are contiguous, so no gap at the seam
    if (addr <= ipq_pkg::SECOND_LOCAL_RAM_BLOCK_END)
    begin
      region = ipq_pkg::IPQ_RAM;
    end
    else if (addr >= ipq_pkg::SHARED_RAM_BLOCK_ELEVEN_BASE && addr <= ipq_pkg::SHARED_RAM_BLOCK_ELEVEN_END)
    begin
      region = ipq_pkg::IPQ_RAM;
    end
    else if (addr >= ipq_pkg::SHARED_RAM_BLOCK_FIFTEEN_BASE && addr <= ipq_pkg::SHARED_RAM_BLOCK_FIFTEEN_END)
    begin
      region = ipq_pkg::IPQ_RAM;
    end
    else if (addr >= ipq_pkg::FLASH_BASE && addr <= ipq_pkg::FLASH_END)
    begin
      region = ipq_pkg::IPQ_FLASH;
    end
    else
    begin
      region = ipq_pkg::IPQ_UNMAPPED;
    end
  end
endmodule

// *** tb/ipq_memory_model.sv ***
// ipq_memory_model: behavioural ram and flash answering prefetch fetches.
// assumes one fetch per cycle at most and the memory map of ipq_pkg.
`timescale 1ns/1ps
module ipq_memory_model
(
  input wire ipq_pkg::ipq_fetch_t fetch,
  output logic [15:0] mem_rdata,
  output logic mem_ecc_err
);
  function automatic logic mapped(input logic [21:0] a);
    return (a <= ipq_pkg::SECOND_LOCAL_RAM_BLOCK_END) ||
      (a >= ipq_pkg::SHARED_RAM_BLOCK_ELEVEN_BASE && a <= ipq_pkg::SHARED_RAM_BLOCK_ELEVEN_END) ||
      (a >= ipq_pkg::SHARED_RAM_BLOCK_FIFTEEN_BASE && a <= ipq_pkg::SHARED_RAM_BLOCK_FIFTEEN_END) ||
      (a >= ipq_pkg::FLASH_BASE && a <= ipq_pkg::FLASH_END);
  endfunction

  // answers while the fetch stands, since the queue pushes the word at the next edge;
  // the two local ram blocks answer as one span across the seam
  always_comb
  begin
    // no held data between answers: the bus shows the inverse so stale words cannot pass
    mem_rdata = ~{1'b1, fetch.addr[14:0]};
    mem_ecc_err = 1'b0;
    if (fetch.valid && mapped(fetch.addr))
    begin
      mem_rdata = {1'b1, fetch.addr[14:0]};
    end
    else if (fetch.valid && fetch.addr > ipq_pkg::FLASH_END)
    begin
      mem_ecc_err = 1'b1;
    end
  end
endmodule

// *** tb/instruction_prefetch_queue_test.sv ***
// instruction_prefetch_queue_test: self-checking bench for the prefetch queue.
// assumes ipq_memory_model on the fetch side; the bench plays the execute stage.
`timescale 1ns/1ps
module instruction_prefetch_queue_test;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic flush = 1'b0;
  logic [21:0] flush_addr = 22'h00_0000;
  logic issue_ready = 1'b0;
  logic [15:0] mem_rdata;
  logic mem_ecc_err;
  ipq_pkg::ipq_fetch_t fetch;
  logic issue_valid;
  ipq_pkg::ipq_entry_t issue;
  logic illegal_op_trap;
  logic ecc_fault_trap;
  int mismatches = 0;
  int samples_checked = 0;

  always #12.5 clock = ~clock;

  ipq_prefetch_queue dut_u (.clock(clock), .srst(srst), .flush(flush), .flush_addr(flush_addr),
    .mem_rdata(mem_rdata), .mem_ecc_err(mem_ecc_err), .issue_ready(issue_ready), .fetch(fetch),
    .issue_valid(issue_valid), .issue(issue), .illegal_op_trap(illegal_op_trap), .ecc_fault_trap(ecc_fault_trap));
  ipq_memory_model mem_u (.fetch(fetch), .mem_rdata(mem_rdata), .mem_ecc_err(mem_ecc_err));

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic redirect(input logic [21:0] a);
    @(negedge clock);
    issue_ready = 1'b0;
    flush = 1'b1;
    flush_addr = a;
    @(negedge clock);
    flush = 1'b0;
  endtask

  // take ngood good words from start, then one faulty word of kind 1 (opcode) or 2 (ecc); kind 0 takes none
  task automatic run(input logic [21:0] start, input int ngood, input int kind);
    int i;
    int guard;
    logic prev_bad;
    logic prev_ecc;
    i = 0;
    guard = 0;
    prev_bad = 1'b0;
    prev_ecc = 1'b0;
    redirect(start);
    issue_ready = 1'b1;
    while (i <= ngood && guard < 200)
    begin
      @(negedge clock);
      guard++;
      check("illegal_op_trap", illegal_op_trap, prev_bad);
      check("ecc_fault_trap", ecc_fault_trap, prev_ecc);
      prev_bad = 1'b0;
      prev_ecc = 1'b0;
      if (issue_valid === 1'b1)
      begin
        if (i == ngood && kind == 0)
          break;
        check("issue.addr", issue.addr, start + 22'(i));
        if (i < ngood)
        begin
          check("issue.word", issue.word, {1'b1, 15'(start + 22'(i))});
          check("issue.flags", {issue.bad_opcode, issue.ecc_fault}, 2'b00);
        end
        else if (kind == 1)
        begin
          check("bad word", issue.word, ipq_pkg::INVALID_OPCODE);
          check("bad flag", issue.bad_opcode, 1'b1);
          prev_bad = 1'b1;
        end
        else
        begin
          check("ecc flag", issue.ecc_fault, 1'b1);
          prev_ecc = 1'b1;
        end
        i++;
      end
    end
    check("words taken", 40'(i), 40'(kind == 0 ? ngood : ngood + 1));
    @(negedge clock);
    check("late illegal_op_trap", illegal_op_trap, prev_bad);
    check("late ecc_fault_trap", ecc_fault_trap, prev_ecc);
    issue_ready = 1'b0;
  endtask

  // stall execute and count how far ahead the queue runs; nothing may trap meanwhile
  task automatic depth(input logic [21:0] start, input int exp);
    int n;
    n = 0;
    redirect(start);
    repeat (60)
    begin
      @(negedge clock);
      if (fetch.valid === 1'b1)
        n++;
      check("stalled traps", {illegal_op_trap, ecc_fault_trap}, 2'b00);
    end
    // the word held on issue sits outside the queue, so one fetch more than the depth
    check("fetches ahead", 40'(n), 40'(exp + 1));
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(negedge clock);
    srst = 1'b0;
    run(22'h00_03F8, 16, 0);
    run(22'h00_07F0, 16, 1);
    run(22'h01_7FF8, 8, 1);
    run(22'h01_BFF8, 8, 1);
    run(22'h0B_FFF0, 16, 2);
    depth(22'h00_0100, ipq_pkg::RAM_DEPTH);
    depth(22'h0A_0000, ipq_pkg::FLASH_DEPTH);
    depth(22'h00_07FC, ipq_pkg::RAM_DEPTH);
    run(22'h00_0200, 4, 0);
    summarize();
  end

  // about 300 cycles are needed; give over ten times that
  initial
  begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
